// ---- rtl/cfi_pkg.sv ----
package cfi_pkg;

    // ------------------------------------------------------------
    // Register map, byte addresses on the AXI4-Lite slave
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_INT_STAT = 8'h08;
    localparam logic [7:0] OFS_INT_MASK = 8'h0c;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_W = 4;
    localparam logic [3:0] CTRL_RST = 4'h0;

    localparam int INT_W = 5;
    localparam int INT_READY = 0;
    localparam int INT_ALIGN = 1;
    localparam int INT_OVH_FP = 2;
    localparam int INT_TX_FP = 3;
    localparam int INT_RX_FP = 4;
    localparam logic [4:0] INT_MASK_RST = 5'h00;
    localparam logic [4:0] INT_STAT_RST = 5'h00;

    localparam int STAT_READY = 0;
    localparam int STAT_CFG_DONE = 1;
    localparam int STAT_PROT_FIRST = 2;
    localparam int STAT_PROT_SECOND = 3;
    localparam int STAT_OVH_EN_A = 4;
    localparam int STAT_SIDE = 5;

    // ------------------------------------------------------------
    // Core register port, reached by either CPU bus
    // ------------------------------------------------------------
    localparam logic [6:0] CORE_OFS_SCRATCH = 7'h00;
    localparam logic [6:0] CORE_OFS_STATUS = 7'h01;
    localparam logic [7:0] CORE_SCRATCH_RST = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int READY_DELAY_CYC = 6;
    localparam logic [2:0] READY_LAST = 3'(READY_DELAY_CYC - 1);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RDY_WAIT,
        RDY_COUNT,
        RDY_UP
    } cfi_ready_e;

    typedef struct packed {
        logic hiz_a;
        logic cha_en;
        logic gate;
        logic side;
    } cfi_ctrl_s;

    typedef struct packed {
        logic cs;
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } cfi_cpu_req_s;

endpackage : cfi_pkg

// ---- rtl/cfi_sync.sv ----
`timescale 1ns/1ns
module cfi_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Asynchronous in, synchronous out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] stage1;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= '0;
            q <= '0;
        end else begin
            stage1 <= d;
            q <= stage1;
        end
    end

endmodule : cfi_sync

// ---- rtl/cfi_align.sv ----
`timescale 1ns/1ns
module cfi_align (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // One-cycle frame events from the four streams
    input wire logic [3:0] chan_frame,
    // Aligned position
    output logic aligned_frame_marker
);

    logic [3:0] seen;
    logic [3:0] next_seen;
    logic next_marker;

    // A stream that frames twice before the slowest one is counted once;
    // the marker follows one cycle after the last of the four arrives.
    always_comb begin
        next_seen = seen | chan_frame;
        next_marker = 1'b0;
        if (&next_seen) begin
            next_seen = 4'h0;
            next_marker = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            seen <= 4'h0;
            aligned_frame_marker <= 1'b0;
        end else begin
            seen <= next_seen;
            aligned_frame_marker <= next_marker;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    AST_ALIGN_ALL: assert property (
        aligned_frame_marker |-> $past(&(seen | chan_frame))
    ) else $error("aligned marker without all four frames");

    AST_ALIGN_ONCE: assert property (
        aligned_frame_marker |=> !aligned_frame_marker || $past(&chan_frame)
    ) else $error("aligned marker repeated without new frames");

    COV_ALIGN: cover property (aligned_frame_marker);

endmodule : cfi_align

// ---- rtl/cfi_core.sv ----
`timescale 1ns/1ns
module cfi_core (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq,
    // Configuration and ready
    input wire logic cfg_done,
    output logic core_ready,
    // Core-side microprocessor pins
    input wire logic [6:0] mp_addr,
    input wire logic [7:0] mp_db_in,
    output logic [7:0] mp_db_out,
    output logic mp_db_oe,
    input wire logic mp_rd_wr_n,
    input wire logic mp_cs_n,
    output logic mp_int_n_out,
    output logic mp_int_n_oe,
    // Fabric-side CPU bus
    input wire logic [7:0] fab_cpu_wdata,
    input wire logic [6:0] fab_cpu_addr,
    input wire logic fab_cpu_rd_wr_n,
    input wire logic fab_cpu_cs_n,
    output logic [7:0] fab_cpu_rdata,
    output logic fab_cpu_int_n,
    // Fabric frame and protection controls
    input wire logic transmit_frame_marker,
    input wire logic receive_frame_marker,
    input wire logic protection_switch_first,
    input wire logic protection_switch_second,
    // Receive overhead serial link
    input wire logic ovh_link_clk,
    input wire logic ovh_rx_data_d,
    input wire logic ovh_rx_frame,
    output logic overhead_clk_pulse_gate_bit,
    output logic overhead_receive_clock_gate,
    output logic overhead_receive_frame_marker,
    output logic overhead_receive_data_d,
    output logic ovh_enable_a,
    // Alignment and recovered clocks
    input wire logic [3:0] chan_frame_toggle,
    output logic aligned_frame_marker,
    input wire logic [3:0] cdr_clk_in,
    output logic [3:0] recovered_clk
);

    // ------------------------------------------------------------
    // Synchronisers for everything from outside the mclk domain
    // ------------------------------------------------------------
    logic cfg_s;
    logic [16:0] mp_s;
    logic mp_cs_q;
    logic [2:0] lk_s;
    logic [3:0] tog_s;
    logic [3:0] tog_prev;
    logic [3:0] cdr_s;
    cfi_pkg::cfi_cpu_req_s mp_req;
    cfi_pkg::cfi_cpu_req_s fab_req;
    cfi_pkg::cfi_cpu_req_s sel_req;

    cfi_sync #(.W(1)) u_sync_cfg (.mclk(mclk), .rst_b(rst_b),
        .d(cfg_done), .q(cfg_s));
    cfi_sync #(.W(17)) u_sync_mp (.mclk(mclk), .rst_b(rst_b),
        .d({~mp_cs_n, mp_rd_wr_n, mp_addr, mp_db_in}), .q(mp_s));
    cfi_sync #(.W(3)) u_sync_lk (.mclk(mclk), .rst_b(rst_b),
        .d({ovh_link_clk, ovh_rx_data_d, ovh_rx_frame}), .q(lk_s));
    cfi_sync #(.W(4)) u_sync_tog (.mclk(mclk), .rst_b(rst_b),
        .d(chan_frame_toggle), .q(tog_s));
    cfi_sync #(.W(4)) u_sync_cdr (.mclk(mclk), .rst_b(rst_b),
        .d(cdr_clk_in), .q(cdr_s));

    cfi_align u_align (.mclk(mclk), .rst_b(rst_b),
        .chan_frame(tog_s ^ tog_prev),
        .aligned_frame_marker(aligned_frame_marker));

    // ------------------------------------------------------------
    // Ready sequencing
    // ------------------------------------------------------------
    cfi_pkg::cfi_ready_e rdy_state;
    cfi_pkg::cfi_ready_e next_rdy_state;
    logic [2:0] rdy_cnt;
    logic [2:0] next_rdy_cnt;
    logic next_core_ready;

    always_comb begin
        next_rdy_state = rdy_state;
        next_rdy_cnt = rdy_cnt;
        case (rdy_state)
            cfi_pkg::RDY_WAIT: begin
                if (cfg_s) begin
                    next_rdy_state = cfi_pkg::RDY_COUNT;
                    next_rdy_cnt = 3'h0;
                end
            end
            cfi_pkg::RDY_COUNT: begin
                if (rdy_cnt == cfi_pkg::READY_LAST) begin
                    next_rdy_state = cfi_pkg::RDY_UP;
                end else begin
                    next_rdy_cnt = rdy_cnt + 3'h1;
                end
            end
            default: next_rdy_state = cfi_pkg::RDY_UP;
        endcase
        next_core_ready = (next_rdy_state == cfi_pkg::RDY_UP);
    end

    // ------------------------------------------------------------
    // Register port shared by the two CPU buses
    // ------------------------------------------------------------
    cfi_pkg::cfi_ctrl_s ctrl;
    logic [4:0] int_stat;
    logic [4:0] int_mask;
    logic [4:0] next_int_stat;
    logic [4:0] next_int_mask;
    logic [4:0] events;
    logic int_any;
    logic sel_cs_prev;
    logic core_access;
    logic [7:0] scratch;
    logic [7:0] next_scratch;
    logic [7:0] core_rdata;
    logic [7:0] next_fab_rdata;

    always_comb begin
        mp_req = mp_s;
        // The select may resolve a sample before the data; act one later.
        mp_req.cs = mp_s[16] && mp_cs_q;
        fab_req = {~fab_cpu_cs_n, fab_cpu_rd_wr_n,
                   fab_cpu_addr, fab_cpu_wdata};
        sel_req = ctrl.side ? fab_req : mp_req;
        int_any = |(next_int_stat & next_int_mask);
        // Until core_ready is high no write to the core scratch register is acted upon.
        core_access = sel_req.cs && !sel_cs_prev && core_ready;
        if (sel_req.addr == cfi_pkg::CORE_OFS_SCRATCH) begin
            core_rdata = scratch;
        end else if (sel_req.addr == cfi_pkg::CORE_OFS_STATUS) begin
            core_rdata = {6'h00, int_any, core_ready};
        end else begin
            core_rdata = 8'h00;
        end
        next_scratch = scratch;
        if (core_access && !sel_req.rd &&
            sel_req.addr == cfi_pkg::CORE_OFS_SCRATCH) begin
            next_scratch = sel_req.wdata;
        end
        next_fab_rdata = fab_cpu_rdata;
        if (ctrl.side && fab_req.cs && fab_req.rd) begin
            next_fab_rdata = core_rdata;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave and register file
    // ------------------------------------------------------------
    cfi_pkg::cfi_ctrl_s next_ctrl;
    logic next_awready;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_arready;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic wr_go;
    logic [5:0] status_word;

    always_comb begin
        next_awready = 1'b0;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        next_arready = 1'b0;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        next_ctrl = ctrl;
        next_int_mask = int_mask;
        events = 5'h00;
        events[cfi_pkg::INT_READY] = next_core_ready && !core_ready;
        events[cfi_pkg::INT_ALIGN] = aligned_frame_marker;
        events[cfi_pkg::INT_OVH_FP] = overhead_receive_frame_marker;
        events[cfi_pkg::INT_TX_FP] = transmit_frame_marker;
        events[cfi_pkg::INT_RX_FP] = receive_frame_marker;
        next_int_stat = int_stat;
        status_word = 6'h00;
        status_word[cfi_pkg::STAT_READY] = core_ready;
        status_word[cfi_pkg::STAT_CFG_DONE] = cfg_s;
        status_word[cfi_pkg::STAT_PROT_FIRST] = protection_switch_first;
        status_word[cfi_pkg::STAT_PROT_SECOND] = protection_switch_second;
        status_word[cfi_pkg::STAT_OVH_EN_A] = ovh_enable_a;
        status_word[cfi_pkg::STAT_SIDE] = ctrl.side;
        wr_go = s_axi_awready;
        if (wr_go) begin
            next_bvalid = 1'b1;
            next_bresp = cfi_pkg::RESP_OKAY;
            if (s_axi_awaddr == cfi_pkg::OFS_CTRL) begin
                if (s_axi_wstrb[0]) begin
                    next_ctrl = s_axi_wdata[cfi_pkg::CTRL_W-1:0];
                end
            end else if (s_axi_awaddr == cfi_pkg::OFS_INT_STAT) begin
                if (s_axi_wstrb[0]) begin
                    next_int_stat = int_stat & ~s_axi_wdata[4:0];
                end
            end else if (s_axi_awaddr == cfi_pkg::OFS_INT_MASK) begin
                if (s_axi_wstrb[0]) begin
                    next_int_mask = s_axi_wdata[4:0];
                end
            end else if (s_axi_awaddr != cfi_pkg::OFS_STATUS) begin
                next_bresp = cfi_pkg::RESP_SLVERR;
            end
        end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid) begin
            next_awready = 1'b1;
        end
        // A new event wins over a clear in the same cycle.
        next_int_stat = next_int_stat | events;
        if (s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = cfi_pkg::RESP_OKAY;
            if (s_axi_araddr == cfi_pkg::OFS_CTRL) begin
                next_rdata = {28'h0000000, ctrl};
            end else if (s_axi_araddr == cfi_pkg::OFS_STATUS) begin
                next_rdata = {26'h0000000, status_word};
            end else if (s_axi_araddr == cfi_pkg::OFS_INT_STAT) begin
                next_rdata = {27'h0000000, int_stat};
            end else if (s_axi_araddr == cfi_pkg::OFS_INT_MASK) begin
                next_rdata = {27'h0000000, int_mask};
            end else begin
                next_rdata = 32'h00000000;
                next_rresp = cfi_pkg::RESP_SLVERR;
            end
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            next_arready = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Overhead link, sampled on rising edges of its own clock
    // ------------------------------------------------------------
    logic lk_prev;
    logic lk_rise;

    assign lk_rise = lk_s[2] && !lk_prev;

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rdy_state <= cfi_pkg::RDY_WAIT;
            rdy_cnt <= 3'h0;
            core_ready <= 1'b0;
            ctrl <= cfi_pkg::CTRL_RST;
            int_stat <= cfi_pkg::INT_STAT_RST;
            int_mask <= cfi_pkg::INT_MASK_RST;
            irq <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= cfi_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= cfi_pkg::RESP_OKAY;
            sel_cs_prev <= 1'b0;
            mp_cs_q <= 1'b0;
            scratch <= cfi_pkg::CORE_SCRATCH_RST;
            fab_cpu_rdata <= 8'h00;
            fab_cpu_int_n <= 1'b1;
            mp_db_out <= 8'h00;
            mp_db_oe <= 1'b0;
            mp_int_n_out <= 1'b0;
            mp_int_n_oe <= 1'b0;
            lk_prev <= 1'b0;
            tog_prev <= 4'h0;
            overhead_clk_pulse_gate_bit <= 1'b0;
            overhead_receive_clock_gate <= 1'b0;
            overhead_receive_frame_marker <= 1'b0;
            overhead_receive_data_d <= 1'b0;
            ovh_enable_a <= 1'b0;
            recovered_clk <= 4'h0;
        end else begin
            rdy_state <= next_rdy_state;
            rdy_cnt <= next_rdy_cnt;
            core_ready <= next_core_ready;
            ctrl <= next_ctrl;
            int_stat <= next_int_stat;
            int_mask <= next_int_mask;
            irq <= int_any;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_awready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            sel_cs_prev <= sel_req.cs;
            mp_cs_q <= mp_s[16];
            scratch <= next_scratch;
            fab_cpu_rdata <= next_fab_rdata;
            fab_cpu_int_n <= !(ctrl.side && int_any);
            mp_db_out <= core_rdata;
            mp_db_oe <= !ctrl.side && mp_req.cs && mp_req.rd;
            mp_int_n_out <= 1'b0;
            mp_int_n_oe <= !ctrl.side && int_any;
            lk_prev <= lk_s[2];
            tog_prev <= tog_s;
            overhead_clk_pulse_gate_bit <= ctrl.gate;
            overhead_receive_clock_gate <= ctrl.gate && lk_rise;
            overhead_receive_frame_marker <= ctrl.gate && lk_rise && lk_s[0];
            overhead_receive_data_d <= lk_rise ? lk_s[1]
                                               : overhead_receive_data_d;
            ovh_enable_a <= ctrl.cha_en && ctrl.hiz_a;
            recovered_clk <= cdr_s;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    AST_READY_LOW: assert property (
        rdy_state == cfi_pkg::RDY_WAIT |-> !core_ready
    ) else $error("ready high before configuration done");

    AST_READY_DELAY: assert property (
        $rose(cfg_s) && rdy_state == cfi_pkg::RDY_WAIT
            |=> !core_ready [*6] ##1 core_ready
    ) else $error("ready not high exactly six cycles after config");

    AST_READY_HOLD: assert property (
        core_ready |=> core_ready
    ) else $error("ready fell while out of reset");

    AST_SIDE_WRITE: assert property (
        !ctrl.side && !mp_req.cs && $past(!ctrl.side)
            |=> scratch == $past(scratch)
    ) else $error("unselected fabric bus changed core register");

    AST_GATE_OFF: assert property (
        !ctrl.gate |=> !overhead_receive_clock_gate
            && !overhead_receive_frame_marker
    ) else $error("overhead enable delivered while gated off");

    AST_EN_A: assert property (
        ##1 ovh_enable_a == $past(ctrl.cha_en && ctrl.hiz_a)
    ) else $error("channel A overhead enable not the AND");

    AST_RCLK: assert property (
        ##3 recovered_clk == $past(cdr_clk_in, 3)
    ) else $error("recovered clock not forwarded per channel");

    AST_OVH_DATA: assert property (
        overhead_receive_clock_gate
            |-> overhead_receive_data_d == $past(lk_s[1]) && $past(ctrl.gate)
    ) else $error("overhead data not sampled with its enable");

    AST_FAB_QUIET: assert property (
        !ctrl.side |=> fab_cpu_int_n && fab_cpu_rdata == $past(fab_cpu_rdata)
    ) else $error("fabric bus active while core pins selected");

    AST_IRQ: assert property (
        ##1 irq == $past(|(next_int_stat & next_int_mask))
    ) else $error("interrupt output does not follow status and mask");

    COV_READY: cover property ($rose(core_ready));
    COV_FAB_READ: cover property (ctrl.side && core_access && sel_req.rd);
    COV_OVH_FP: cover property (overhead_receive_frame_marker);
    COV_IRQ: cover property ($rose(irq));

endmodule : cfi_core

// ---- tb/cfi_fabric_model.sv ----
`timescale 1ns/1ns
module cfi_fabric_model (
    // Clock
    input wire logic mclk,
    // Fabric CPU bus toward the core
    output logic [7:0] wdata,
    output logic [6:0] addr,
    output logic rd_wr_n,
    output logic cs_n,
    // Frame and protection controls
    output logic tx_fp,
    output logic rx_fp,
    output logic [1:0] prot
);
    initial begin
        {wdata, addr, rd_wr_n, cs_n, tx_fp, rx_fp, prot} = 21'h000030;
    end

    // Held three cycles, two more than the core needs; released data
    // lines show the inverse so a stale value cannot pass.
    task automatic acc(input logic rw, input logic [6:0] a,
                       input logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        rd_wr_n <= rw;
        cs_n <= 1'b0;
        repeat (3) @(posedge mclk);
        cs_n <= 1'b1;
        wdata <= ~v;
    endtask : acc

    task automatic fp(input logic rx);
        @(posedge mclk);
        rx_fp <= rx;
        tx_fp <= ~rx;
        @(posedge mclk);
        rx_fp <= 1'b0;
        tx_fp <= 1'b0;
    endtask : fp

    task automatic sw(input logic [1:0] v);
        @(posedge mclk);
        prot <= v;
    endtask : sw
endmodule : cfi_fabric_model

// ---- tb/cfi_core_tb_top.sv ----
`timescale 1ns/1ns
module cfi_core_tb_top;
    logic mclk = 1'b0, rst_b = 1'b0, cfg_done = 1'b0, irq, core_ready;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [6:0] mp_addr = 7'h00, fab_cpu_addr;
    logic [7:0] mp_db_in = 8'h00, mp_db_out, fab_cpu_wdata, fab_cpu_rdata;
    logic mp_rd_wr_n = 1'b1, mp_cs_n = 1'b1, mp_db_oe, mp_int_n_out;
    logic mp_int_n_oe, fab_cpu_rd_wr_n, fab_cpu_cs_n, fab_cpu_int_n;
    logic transmit_frame_marker, receive_frame_marker;
    logic protection_switch_first, protection_switch_second;
    logic ovh_link_clk = 1'b0, ovh_rx_data_d = 1'b0, ovh_rx_frame = 1'b0;
    logic overhead_clk_pulse_gate_bit, overhead_receive_clock_gate;
    logic overhead_receive_frame_marker, overhead_receive_data_d;
    logic ovh_enable_a, aligned_frame_marker;
    logic [3:0] chan_frame_toggle = 4'h0, cdr_clk_in = 4'h0, recovered_clk;
    int n_mismatch = 0, compares = 0, nck = 0, nfp = 0, nal = 0;

    cfi_core i_cfi_core (.*);
    cfi_fabric_model i_cfi_fabric_model (.mclk(mclk),
        .wdata(fab_cpu_wdata), .addr(fab_cpu_addr),
        .rd_wr_n(fab_cpu_rd_wr_n), .cs_n(fab_cpu_cs_n),
        .tx_fp(transmit_frame_marker), .rx_fp(receive_frame_marker),
        .prot({protection_switch_second, protection_switch_first}));

    initial forever #20 mclk = ~mclk;
    always @(posedge mclk) if (overhead_receive_clock_gate === 1'b1) nck++;
    always @(posedge mclk) if (overhead_receive_frame_marker === 1'b1) nfp++;
    always @(posedge mclk) if (aligned_frame_marker === 1'b1) nal++;

    // ------------------------------------------------------------
    // Bus tasks and checking
    // ------------------------------------------------------------
    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // The master never assumes a latency; only this bound ends a wait.
    task automatic hs(ref logic s);
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (s !== 1'b1 && n < 50);
        if (s !== 1'b1) begin
            n_mismatch++;
            summarize();
        end
    endtask : hs

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        hs(s_axi_awready);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        hs(s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        hs(s_axi_arready);
        s_axi_arvalid <= 1'b0;
        hs(s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic mp(input logic rw, input logic [7:0] v, x);
        @(posedge mclk);
        mp_rd_wr_n <= rw;
        mp_db_in <= v;
        mp_cs_n <= 1'b0;
        repeat (6) @(posedge mclk);
        #1;
        chk("mp_db_oe", rw, mp_db_oe);
        if (rw) chk("mp_db_out", x, mp_db_out);
        @(posedge mclk);
        mp_cs_n <= 1'b1;
        mp_db_in <= ~v;
    endtask : mp

    task automatic fab(input logic rw, input logic [7:0] v, x);
        i_cfi_fabric_model.acc(rw, 7'h00, v);
        #1;
        if (rw) chk("fab_cpu_rdata", x, fab_cpu_rdata);
    endtask : fab

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        #1;
        chk("core_ready", 0, core_ready);
        rd(cfi_pkg::OFS_CTRL);
        cfg_done <= 1'b1;
        chk("ctrl", 0, d);
        repeat (8) @(posedge mclk);
        #1;
        chk("ready low", 0, core_ready);
        repeat (2) @(posedge mclk);
        #1;
        chk("ready high", 1, core_ready);
        rd(cfi_pkg::OFS_STATUS);
        chk("status", 3, d & 32'h3);
        $display("test ready done");
        for (int i = 0; i < 4; i++) begin
            wr(cfi_pkg::OFS_CTRL, 32'(i * 4 + 2));
            #1;
            chk("ovh_enable_a", i == 3, ovh_enable_a);
        end
        chk("gate", 1, overhead_clk_pulse_gate_bit);
        for (int k = 0; k < 5; k++) begin
            if (k == 4) wr(cfi_pkg::OFS_CTRL, 32'h0c);
            #7;
            ovh_rx_data_d = k[0];
            ovh_rx_frame = (k == 0);
            ovh_link_clk = 1'b1;
            #160;
            chk("ovh data", k[0], overhead_receive_data_d);
            ovh_link_clk = 1'b0;
            ovh_rx_data_d = ~k[0];
            // With the offset above the link period stays at 320 ns.
            #153;
        end
        repeat (6) @(posedge mclk);
        chk("clock gate pulses", 4, nck);
        chk("frame pulses", 1, nfp);
        $display("test overhead link done");
        fab(1'b0, 8'h5a, 8'h00);
        mp(1'b1, 8'h00, 8'h00);
        wr(cfi_pkg::OFS_CTRL, 32'h1);
        mp(1'b0, 8'ha5, 8'h00);
        fab(1'b1, 8'h00, 8'h00);
        fab(1'b0, 8'h5a, 8'h00);
        fab(1'b1, 8'h00, 8'h5a);
        $display("test port select done");
        wr(cfi_pkg::OFS_INT_STAT, 32'h1f);
        chk("bresp", cfi_pkg::RESP_OKAY, r);
        wr(cfi_pkg::OFS_INT_MASK, 32'h08);
        i_cfi_fabric_model.fp(1'b1);
        rd(cfi_pkg::OFS_INT_STAT);
        chk("int_stat", 32'h10, d);
        chk("irq masked", 0, irq);
        i_cfi_fabric_model.fp(1'b0);
        repeat (3) @(posedge mclk);
        #1;
        chk("irq", 1, irq);
        chk("fab_cpu_int_n", 0, fab_cpu_int_n);
        i_cfi_fabric_model.acc(1'b1, 7'h01, 8'h00);
        #1;
        chk("core status", 8'h03, fab_cpu_rdata);
        wr(cfi_pkg::OFS_CTRL, 32'h0);
        #1;
        chk("mp_int_n_oe", 1, mp_int_n_oe);
        chk("mp_int_n_out", 0, mp_int_n_out);
        chk("fab int released", 1, fab_cpu_int_n);
        wr(cfi_pkg::OFS_INT_STAT, 32'h18);
        repeat (2) @(posedge mclk);
        #1;
        chk("irq cleared", 0, irq);
        rd(8'h10);
        chk("unmapped resp", cfi_pkg::RESP_SLVERR, r);
        wr(8'h10, 32'h0);
        chk("unmapped wr resp", cfi_pkg::RESP_SLVERR, r);
        $display("test interrupts done");
        for (int c = 0; c < 4; c++) begin
            repeat (4) @(posedge mclk);
            chan_frame_toggle[c] <= 1'b1;
        end
        repeat (8) @(posedge mclk);
        chk("aligned pulses", 1, nal);
        i_cfi_fabric_model.sw(2'b10);
        rd(cfi_pkg::OFS_STATUS);
        chk("protection", 32'h8, d & 32'hc);
        for (int j = 0; j < 2; j++) begin
            @(posedge mclk);
            cdr_clk_in <= j ? 4'ha : 4'h5;
            repeat (5) @(posedge mclk);
            #1;
            chk("recovered_clk", j ? 10 : 5, recovered_clk);
        end
        $display("test align and clocks done");
        summarize();
    end
endmodule : cfi_core_tb_top
